// ==== src/mpf_defs.vh ====
/*
  Register map, field positions, reset values and programming-mode
  encodings for the port pin block. Included by every design file.
*/
`ifndef MPF_DEFS_VH
`define MPF_DEFS_VH

// ----
// register byte offsets on the Avalon-MM slave
// ----
`define MPF_OFS_OUT_A 8'h00
`define MPF_OFS_OUT_B 8'h04
`define MPF_OFS_OUT_C 8'h08
`define MPF_OFS_OUT_D 8'h0C
`define MPF_OFS_OUT_E 8'h10
`define MPF_OFS_DIR 8'h14
`define MPF_OFS_PULLUP 8'h18
`define MPF_OFS_ALT 8'h1C
`define MPF_OFS_PIN_IN 8'h20
`define MPF_OFS_IRQ_STS 8'h24
`define MPF_OFS_IRQ_CLR 8'h28
`define MPF_OFS_IRQ_EN 8'h2C
`define MPF_OFS_PROG 8'h30

// ----
// field positions
// ----
`define MPF_DIR_A_BIT 0
`define MPF_DIR_B_BIT 1
`define MPF_DIR_E_BIT 2
`define MPF_DIR_C_LSB 4
`define MPF_DIR_D_LSB 8
`define MPF_PU_A_BIT 0
`define MPF_PU_B_BIT 1
`define MPF_PU_E_BIT 2
`define MPF_PU_D_LSB 4
`define MPF_ALT_TMR_BIT 0
`define MPF_ALT_SO_BIT 1
`define MPF_ALT_SCK_BIT 2
`define MPF_IRQ_RLS_BIT 0
`define MPF_IRQ_INT_BIT 1
`define MPF_IRQ_STEP_BIT 2

// ----
// reset values
// ----
`define MPF_RST_NIB 4'h0
`define MPF_RST_GRP 3'h0
`define MPF_RST_IRQ 3'h0

// ----
// programming mode-select codes, bit n is mode select input n
// ----
`define MPF_MD_ADDR_CLR 4'h5
`define MPF_MD_WRITE 4'hE
`define MPF_MD_VERIFY 4'hC
`define MPF_MD_INH_MASK 4'hD
`define MPF_MD_INH_CODE 4'hD
`define MPF_PULSES_PER_ADDR 3'h4

`endif

// ==== src/mpf_nibble_port.v ====
/*
  One 4-bit port cell: registered pin drive, output enable and pull-up,
  registered pin sample. Assumes pins are synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module mpf_nibble_port #(
  parameter OPEN_DRAIN = 0
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [3:0] dir_i,
  input wire [3:0] out_i,
  input wire [3:0] pu_i,
  input wire [3:0] pin_i,
  output reg [3:0] pin_o,
  output reg [3:0] pin_oe_o,
  output reg [3:0] pin_pu_o,
  output reg [3:0] in_o
);
  `include "mpf_defs.vh"

  // ----
  // per-bit drive cells
  // ----
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_bit
      // open drain only pulls low, push-pull drives both levels
      always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_o[i] <= 1'b0;
          pin_oe_o[i] <= 1'b0;
          pin_pu_o[i] <= 1'b0;
          in_o[i] <= 1'b0;
        end else begin
          in_o[i] <= pin_i[i];
          if (OPEN_DRAIN != 0) begin
            pin_o[i] <= 1'b0;
            pin_oe_o[i] <= dir_i[i] & ~out_i[i];
            pin_pu_o[i] <= pu_i[i];
          end else begin
            pin_o[i] <= out_i[i];
            pin_oe_o[i] <= dir_i[i];
            pin_pu_o[i] <= pu_i[i] & ~dir_i[i];
          end
        end
      end
    end
  endgenerate
endmodule

// ==== src/mpf_port_pins.v ====
/*
  Port pin block of a small 4-bit controller: five 4-bit I/O ports, one
  2-bit input port, alternate functions and the program memory
  write/verify pin reuse. Registers over Avalon-MM with waitrequest.
  Assumes all pins are synchronous to clk_sys_i and that the core gives
  the programming-mode entry level, timer carry and serial signals.
*/
// Functional notes
// - the analog-shared port is 4-bit bidirectional with per-bit direction.
// - general ports A and B and the open-drain nibble port switch direction as a whole nibble.
// - pull-ups of general ports A and B and the open-drain nibble port are enabled per nibble.
// - pull-ups of the multi-function open-drain port are enabled per bit.
// - the multi-function open-drain port has per-bit direction.
// - a 2-bit input-only port exists, bit 1 sharing the converter reference pin.
// - bit 0 of the input-only port, driven low, releases standby.
// - multi-function port bit 3 is timer carry out, 2 serial in, 1 serial out, 0 serial clock.
// - the interrupt pin is both an interrupt request and a standby release input.
// - open-drain ports only pull low; other ports drive both levels.
// - in programming mode four mode-select inputs choose the operation.
// - in programming mode an 8-bit data bus is written by the programmer, read on verify.
// - in programming mode an address-update clock steps the internal address.
// - every four update pulses advance the address; verify shows the next word's data.
`timescale 1ns/1ps
module mpf_port_pins #(
  parameter ADDR_W = 12
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire irq_o,
  // general ports a and b (push-pull), data bus in programming mode
  input wire [3:0] general_port_a_i,
  output wire [3:0] general_port_a_o,
  output wire [3:0] general_port_a_oe_o,
  output wire [3:0] general_port_a_pu_o,
  input wire [3:0] general_port_b_i,
  output wire [3:0] general_port_b_o,
  output wire [3:0] general_port_b_oe_o,
  output wire [3:0] general_port_b_pu_o,
  // analog-shared port (push-pull), mode select in programming mode
  input wire [3:0] analog_shared_port_i,
  output wire [3:0] analog_shared_port_o,
  output wire [3:0] analog_shared_port_oe_o,
  // multi-function and nibble open-drain ports
  input wire [3:0] multifunction_od_port_i,
  output wire [3:0] multifunction_od_port_o,
  output wire [3:0] multifunction_od_port_oe_o,
  output wire [3:0] multifunction_od_port_pu_o,
  input wire [3:0] open_drain_nibble_port_i,
  output wire [3:0] open_drain_nibble_port_o,
  output wire [3:0] open_drain_nibble_port_oe_o,
  output wire [3:0] open_drain_nibble_port_pu_o,
  // input-only port and interrupt pin
  input wire [1:0] two_bit_input_port_i,
  input wire ext_int_pin_i,
  // core side alternate functions
  input wire timer_one_carry_out_n_i,
  input wire serial_data_out_i,
  input wire serial_clock_out_i,
  input wire serial_clock_oe_i,
  output reg serial_data_in_o,
  output reg serial_clock_in_o,
  output reg standby_release_o,
  output reg ext_int_req_o,
  // programming mode
  input wire prog_mode_i,
  input wire prog_step_clk_i,
  input wire [7:0] prog_rdata_i,
  output reg [7:0] prog_wdata_o,
  output reg prog_write_o,
  output reg prog_verify_o,
  output wire [ADDR_W-1:0] prog_addr_o
);
  `include "mpf_defs.vh"

  // ----
  // register decode
  // ----
  // one-hot select of the addressed word, zero when unmapped
  function [12:0] reg_sel;
    input [7:0] addr;
    begin
      reg_sel = 13'h0000;
      case (addr)
        `MPF_OFS_OUT_A: reg_sel = 13'h0001;
        `MPF_OFS_OUT_B: reg_sel = 13'h0002;
        `MPF_OFS_OUT_C: reg_sel = 13'h0004;
        `MPF_OFS_OUT_D: reg_sel = 13'h0008;
        `MPF_OFS_OUT_E: reg_sel = 13'h0010;
        `MPF_OFS_DIR: reg_sel = 13'h0020;
        `MPF_OFS_PULLUP: reg_sel = 13'h0040;
        `MPF_OFS_ALT: reg_sel = 13'h0080;
        `MPF_OFS_PIN_IN: reg_sel = 13'h0100;
        `MPF_OFS_IRQ_STS: reg_sel = 13'h0200;
        `MPF_OFS_IRQ_CLR: reg_sel = 13'h0400;
        `MPF_OFS_IRQ_EN: reg_sel = 13'h0800;
        `MPF_OFS_PROG: reg_sel = 13'h1000;
        default: reg_sel = 13'h0000;
      endcase
    end
  endfunction

  reg ack_q;
  wire [12:0] sel;
  wire wr_en;
  wire rd_en;

  reg [3:0] out_a_q, out_b_q, out_c_q, out_d_q, out_e_q;
  reg [2:0] dir_grp_q;
  reg [3:0] dir_c_q, dir_d_q;
  reg [2:0] pu_grp_q;
  reg [3:0] pu_d_q;
  reg [2:0] alt_q;
  reg [2:0] irq_sts_q, irq_en_q;
  reg [1:0] in_f_q;
  reg int_q;
  reg [3:0] md_q;
  wire [3:0] in_a, in_b, in_c, in_d, in_e;
  wire [2:0] irq_evt;
  wire prog_step;

  // one wait cycle, answer on the second cycle of every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign sel = reg_sel(avs_address);
  assign wr_en = avs_write & ~ack_q;
  assign rd_en = avs_read & ~ack_q;

  // ----
  // bus handshake and read data
  // ----
  // read data are captured with the acknowledge
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (rd_en) begin
        case (1'b1)
          sel[0]: avs_readdata <= {28'h0000000, out_a_q};
          sel[1]: avs_readdata <= {28'h0000000, out_b_q};
          sel[2]: avs_readdata <= {28'h0000000, out_c_q};
          sel[3]: avs_readdata <= {28'h0000000, out_d_q};
          sel[4]: avs_readdata <= {28'h0000000, out_e_q};
          sel[5]: avs_readdata <= {20'h00000, dir_d_q, dir_c_q, 1'b0, dir_grp_q};
          sel[6]: avs_readdata <= {24'h000000, pu_d_q, 1'b0, pu_grp_q};
          sel[7]: avs_readdata <= {29'h00000000, alt_q};
          sel[8]: avs_readdata <= {10'h000, in_f_q, in_e, in_d, in_c, in_b, in_a};
          sel[9]: avs_readdata <= {29'h00000000, irq_sts_q};
          sel[11]: avs_readdata <= {29'h00000000, irq_en_q};
          sel[12]: avs_readdata <= {{(16-ADDR_W){1'b0}}, prog_addr_o, 9'h000,
            prog_verify_o, prog_write_o, md_q, prog_mode_i};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----
  // control registers
  // ----
  // all ports input, alternate outputs off after reset
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_a_q <= `MPF_RST_NIB;
      out_b_q <= `MPF_RST_NIB;
      out_c_q <= `MPF_RST_NIB;
      out_d_q <= `MPF_RST_NIB;
      out_e_q <= `MPF_RST_NIB;
      dir_grp_q <= `MPF_RST_GRP;
      dir_c_q <= `MPF_RST_NIB;
      dir_d_q <= `MPF_RST_NIB;
      pu_grp_q <= `MPF_RST_GRP;
      pu_d_q <= `MPF_RST_NIB;
      alt_q <= `MPF_RST_GRP;
      irq_en_q <= `MPF_RST_IRQ;
    end else if (wr_en) begin
      if (sel[0]) out_a_q <= avs_writedata[3:0];
      if (sel[1]) out_b_q <= avs_writedata[3:0];
      if (sel[2]) out_c_q <= avs_writedata[3:0];
      if (sel[3]) out_d_q <= avs_writedata[3:0];
      if (sel[4]) out_e_q <= avs_writedata[3:0];
      if (sel[5]) begin
        dir_grp_q <= avs_writedata[2:0];
        dir_c_q <= avs_writedata[`MPF_DIR_C_LSB+3:`MPF_DIR_C_LSB];
        dir_d_q <= avs_writedata[`MPF_DIR_D_LSB+3:`MPF_DIR_D_LSB];
      end
      if (sel[6]) begin
        pu_grp_q <= avs_writedata[2:0];
        pu_d_q <= avs_writedata[`MPF_PU_D_LSB+3:`MPF_PU_D_LSB];
      end
      if (sel[7]) alt_q <= avs_writedata[2:0];
      if (sel[11]) irq_en_q <= avs_writedata[2:0];
    end
  end

  // ----
  // pin drive selection
  // ----
  wire md_verify;
  wire md_write;
  wire md_clear;
  wire [3:0] dir_a, dir_b, dir_c, dir_d, dir_e;
  wire [3:0] drv_a, drv_b, drv_d;
  wire [3:0] pu_a, pu_b, pu_d, pu_e;

  assign md_clear = prog_mode_i & (md_q == `MPF_MD_ADDR_CLR);
  assign md_write = prog_mode_i & (md_q == `MPF_MD_WRITE);
  assign md_verify = prog_mode_i & (md_q == `MPF_MD_VERIFY);

  // data bus: low nibble on port a, high on port b, driven only on verify
  assign dir_a = prog_mode_i ? {4{md_verify}} : {4{dir_grp_q[`MPF_DIR_A_BIT]}};
  assign dir_b = prog_mode_i ? {4{md_verify}} : {4{dir_grp_q[`MPF_DIR_B_BIT]}};
  assign drv_a = prog_mode_i ? prog_rdata_i[3:0] : out_a_q;
  assign drv_b = prog_mode_i ? prog_rdata_i[7:4] : out_b_q;
  assign dir_c = prog_mode_i ? 4'h0 : dir_c_q;
  assign dir_e = prog_mode_i ? 4'h0 : {4{dir_grp_q[`MPF_DIR_E_BIT]}};

  // multi-function port: alternate enables take over direction and level
  assign dir_d[3] = ~prog_mode_i & (alt_q[`MPF_ALT_TMR_BIT] | dir_d_q[3]);
  assign drv_d[3] = alt_q[`MPF_ALT_TMR_BIT] ? timer_one_carry_out_n_i : out_d_q[3];
  assign dir_d[2] = ~prog_mode_i & dir_d_q[2];
  assign drv_d[2] = out_d_q[2];
  assign dir_d[1] = ~prog_mode_i & (alt_q[`MPF_ALT_SO_BIT] | dir_d_q[1]);
  assign drv_d[1] = alt_q[`MPF_ALT_SO_BIT] ? serial_data_out_i : out_d_q[1];
  assign dir_d[0] = ~prog_mode_i & (alt_q[`MPF_ALT_SCK_BIT] ? serial_clock_oe_i
    : dir_d_q[0]);
  assign drv_d[0] = alt_q[`MPF_ALT_SCK_BIT] ? serial_clock_out_i : out_d_q[0];

  // pull-ups: whole nibble on a, b and e, per bit on d, none while programming
  assign pu_a = prog_mode_i ? 4'h0 : {4{pu_grp_q[`MPF_PU_A_BIT]}};
  assign pu_b = prog_mode_i ? 4'h0 : {4{pu_grp_q[`MPF_PU_B_BIT]}};
  assign pu_e = prog_mode_i ? 4'h0 : {4{pu_grp_q[`MPF_PU_E_BIT]}};
  assign pu_d = prog_mode_i ? 4'h0 : pu_d_q;

  // ----
  // port cells
  // ----
  mpf_nibble_port #(.OPEN_DRAIN(0)) u_port_a (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .dir_i(dir_a),
    .out_i(drv_a),
    .pu_i(pu_a),
    .pin_i(general_port_a_i),
    .pin_o(general_port_a_o),
    .pin_oe_o(general_port_a_oe_o),
    .pin_pu_o(general_port_a_pu_o),
    .in_o(in_a)
  );

  mpf_nibble_port #(.OPEN_DRAIN(0)) u_port_b (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .dir_i(dir_b),
    .out_i(drv_b),
    .pu_i(pu_b),
    .pin_i(general_port_b_i),
    .pin_o(general_port_b_o),
    .pin_oe_o(general_port_b_oe_o),
    .pin_pu_o(general_port_b_pu_o),
    .in_o(in_b)
  );

  mpf_nibble_port #(.OPEN_DRAIN(0)) u_port_c (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .dir_i(dir_c),
    .out_i(out_c_q),
    .pu_i(4'h0),
    .pin_i(analog_shared_port_i),
    .pin_o(analog_shared_port_o),
    .pin_oe_o(analog_shared_port_oe_o),
    .pin_pu_o(),
    .in_o(in_c)
  );

  mpf_nibble_port #(.OPEN_DRAIN(1)) u_port_d (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .dir_i(dir_d),
    .out_i(drv_d),
    .pu_i(pu_d),
    .pin_i(multifunction_od_port_i),
    .pin_o(multifunction_od_port_o),
    .pin_oe_o(multifunction_od_port_oe_o),
    .pin_pu_o(multifunction_od_port_pu_o),
    .in_o(in_d)
  );

  mpf_nibble_port #(.OPEN_DRAIN(1)) u_port_e (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .dir_i(dir_e),
    .out_i(out_e_q),
    .pu_i(pu_e),
    .pin_i(open_drain_nibble_port_i),
    .pin_o(open_drain_nibble_port_o),
    .pin_oe_o(open_drain_nibble_port_oe_o),
    .pin_pu_o(open_drain_nibble_port_pu_o),
    .in_o(in_e)
  );

  // ----
  // programming address stepper
  // ----
  mpf_prog_addr #(.ADDR_W(ADDR_W)) u_prog_addr (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .enable_i(prog_mode_i),
    .clear_i(md_clear),
    .step_pin_i(prog_step_clk_i),
    .addr_o(prog_addr_o),
    .step_o(prog_step)
  );

  // ----
  // input-only port, interrupt pin, serial inputs, programming strobes
  // ----
  // samples and derived levels; mode select read from the analog-shared pins
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_f_q <= 2'h3;
      int_q <= 1'b0;
      md_q <= 4'h0;
      serial_data_in_o <= 1'b0;
      serial_clock_in_o <= 1'b1;
      standby_release_o <= 1'b0;
      ext_int_req_o <= 1'b0;
      prog_wdata_o <= 8'h00;
      prog_write_o <= 1'b0;
      prog_verify_o <= 1'b0;
    end else begin
      in_f_q <= two_bit_input_port_i;
      int_q <= ext_int_pin_i;
      md_q <= prog_mode_i ? analog_shared_port_i : 4'h0;
      serial_data_in_o <= in_d[2];
      serial_clock_in_o <= in_d[0];
      standby_release_o <= ~prog_mode_i & (~two_bit_input_port_i[0] | ext_int_pin_i);
      ext_int_req_o <= ~prog_mode_i & ext_int_pin_i & ~int_q;
      prog_wdata_o <= {general_port_b_i, general_port_a_i};
      prog_write_o <= md_write;
      prog_verify_o <= md_verify;
    end
  end

  // ----
  // interrupt status, set wins over clear
  // ----
  assign irq_evt[`MPF_IRQ_RLS_BIT] = ~prog_mode_i & in_f_q[0] & ~two_bit_input_port_i[0];
  assign irq_evt[`MPF_IRQ_INT_BIT] = ~prog_mode_i & ext_int_pin_i & ~int_q;
  assign irq_evt[`MPF_IRQ_STEP_BIT] = prog_step;

  // sticky status bits cleared by writing ones to the clear word
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_sts_q <= `MPF_RST_IRQ;
    end else begin
      irq_sts_q <= (irq_sts_q & ~({3{wr_en & sel[10]}} & avs_writedata[2:0])) | irq_evt;
    end
  end

  assign irq_o = |(irq_sts_q & irq_en_q);
endmodule

// ==== src/mpf_prog_addr.v ====
/*
  Programming address stepper: counts rising edges of the address-update
  clock pin and advances the address once per group of pulses.
  Assumes the pin is synchronous to clk_sys_i and slower than it.
*/
`timescale 1ns/1ps
module mpf_prog_addr #(
  parameter ADDR_W = 12
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire enable_i,
  input wire clear_i,
  input wire step_pin_i,
  output reg [ADDR_W-1:0] addr_o,
  output reg step_o
);
  `include "mpf_defs.vh"

  reg pin_prev_q;
  reg [2:0] cnt_q;
  wire rise;

  assign rise = enable_i & step_pin_i & ~pin_prev_q;

  // pulse counter and address; clear wins over a pulse
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_prev_q <= 1'b0;
      cnt_q <= 3'h0;
      addr_o <= {ADDR_W{1'b0}};
      step_o <= 1'b0;
    end else begin
      pin_prev_q <= step_pin_i;
      step_o <= 1'b0;
      if (clear_i) begin
        cnt_q <= 3'h0;
        addr_o <= {ADDR_W{1'b0}};
      end else if (rise) begin
        if (cnt_q == `MPF_PULSES_PER_ADDR - 3'h1) begin
          cnt_q <= 3'h0;
          addr_o <= addr_o + {{(ADDR_W-1){1'b0}}, 1'b1};
          step_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end
endmodule

// ==== test/mpf_port_pins_monitor.sv ====
/* assertions on the port pin block, seeing only its ports.
   assumes one clock domain and the active-low async reset. */
`timescale 1ns/1ps
module mpf_port_pins_monitor #(
  parameter ADDR_W = 12
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [3:0] general_port_a_oe_o,
  input wire [3:0] general_port_a_pu_o,
  input wire [3:0] general_port_b_oe_o,
  input wire [3:0] analog_shared_port_oe_o,
  input wire [3:0] multifunction_od_port_oe_o,
  input wire [3:0] multifunction_od_port_o,
  input wire [3:0] open_drain_nibble_port_oe_o,
  input wire [3:0] open_drain_nibble_port_o,
  input wire [1:0] two_bit_input_port_i,
  input wire ext_int_pin_i,
  input wire standby_release_o,
  input wire ext_int_req_o,
  input wire prog_mode_i,
  input wire [3:0] analog_shared_port_i,
  input wire prog_write_o,
  input wire [ADDR_W-1:0] prog_addr_o
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_req_start; $rose(avs_read | avs_write); endsequence
  sequence s_write_code; (prog_mode_i && analog_shared_port_i == 4'hE) [*3]; endsequence
  property p_rst_idle; $rose(rst_n_i) |-> (general_port_a_oe_o | general_port_b_oe_o
    | analog_shared_port_oe_o | multifunction_od_port_oe_o | open_drain_nibble_port_oe_o) == 4'h0;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pin driven after reset");
  property p_od_low; (multifunction_od_port_o | open_drain_nibble_port_o) == 4'h0; endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain pin driven high");
  property p_grp_dir; general_port_a_oe_o inside {4'h0, 4'hF} && general_port_b_oe_o inside
    {4'h0, 4'hF}; endproperty
  a_grp_dir: assert property (p_grp_dir) else $error("group direction split");
  property p_grp_pu; general_port_a_pu_o inside {4'h0, 4'hF}; endproperty
  a_grp_pu: assert property (p_grp_pu) else $error("group pull-up split");
  property p_bus_wait; s_req_start |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus wait count wrong");
  property p_rls; !prog_mode_i && $fell(two_bit_input_port_i[0]) |-> ##[1:2] standby_release_o;
  endproperty
  a_rls: assert property (p_rls) else $error("standby release missing");
  property p_int_req; !prog_mode_i && $rose(ext_int_pin_i) |-> ##[1:3] ext_int_req_o; endproperty
  a_int_req: assert property (p_int_req) else $error("interrupt request missing");
  property p_md_write; s_write_code |-> prog_write_o; endproperty
  a_md_write: assert property (p_md_write) else $error("write mode not decoded");
  property p_addr_step; !$stable(prog_addr_o) |-> prog_addr_o == $past(prog_addr_o) + 1'b1
    || prog_addr_o == '0; endproperty
  a_addr_step: assert property (p_addr_step) else $error("address jumped");
endmodule
bind mpf_port_pins mpf_port_pins_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// ==== test/mpf_port_pins_tb.sv ====
/* self-checking bench for the port pin block.
   assumes the programmer model and the bound monitor. */
`timescale 1ns/1ps
module mpf_port_pins_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} mpf_row_t;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00, prog_rdata_i = 8'h5A, prog_wdata_o, pg_data;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] pa = 4'h1, pb = 4'h2, pc = 4'h3, md = 4'h5, pg_n = 4'h0;
  logic [3:0] multifunction_od_port_i = 4'h4, open_drain_nibble_port_i = 4'h5;
  logic [3:0] general_port_a_i, general_port_a_o, general_port_a_oe_o, general_port_a_pu_o;
  logic [3:0] general_port_b_i, general_port_b_o, general_port_b_oe_o, general_port_b_pu_o;
  logic [3:0] analog_shared_port_i, analog_shared_port_o, analog_shared_port_oe_o;
  logic [3:0] multifunction_od_port_o, multifunction_od_port_oe_o, multifunction_od_port_pu_o;
  logic [3:0] open_drain_nibble_port_o, open_drain_nibble_port_oe_o, open_drain_nibble_port_pu_o;
  logic [1:0] two_bit_input_port_i = 2'b11;
  logic ext_int_pin_i = 1'b0, timer_one_carry_out_n_i = 1'b1, serial_data_out_i = 1'b0;
  logic serial_clock_out_i = 1'b0, serial_clock_oe_i = 1'b0, prog_mode_i = 1'b0;
  logic pg_go = 1'b0, pg_drv = 1'b1, pg_busy, prog_step_clk_i, prog_write_o, prog_verify_o;
  logic avs_waitrequest, irq_o, serial_data_in_o, serial_clock_in_o, standby_release_o;
  logic ext_int_req_o;
  logic [11:0] prog_addr_o;
  int num_errors = 0, samples_checked = 0;
  mpf_row_t rows[12] = '{'{8'h00, 32'h5, 32'h5}, '{8'h04, 32'hA, 32'hA}, '{8'h08, 32'h3, 32'h3},
    '{8'h0C, 32'h9, 32'h9}, '{8'h10, 32'h6, 32'h6}, '{8'h14, 32'hFFF, 32'hFF7},
    '{8'h18, 32'hFF, 32'hF7}, '{8'h1C, 32'h0, 32'h0}, '{8'h2C, 32'h7, 32'h7},
    '{8'h28, 32'h7, 32'h0}, '{8'h24, 32'hFF, 32'h0}, '{8'h40, 32'hFFFF, 32'h0}};
  // pin levels: programmer bus and mode select in programming mode, board levels otherwise
  assign general_port_a_i = prog_mode_i ? (general_port_a_oe_o[0] ? general_port_a_o
    : pg_data[3:0]) : pa;
  assign general_port_b_i = prog_mode_i ? (general_port_b_oe_o[0] ? general_port_b_o
    : pg_data[7:4]) : pb;
  assign analog_shared_port_i = prog_mode_i ? md : pc;
  wire [3:0] oe_all = general_port_a_oe_o | general_port_b_oe_o | analog_shared_port_oe_o
    | multifunction_od_port_oe_o | open_drain_nibble_port_oe_o;
  wire [27:0] pp = {general_port_a_oe_o, general_port_a_o, general_port_a_pu_o,
    general_port_b_oe_o, general_port_b_o, analog_shared_port_oe_o, analog_shared_port_o};
  wire [23:0] od = {multifunction_od_port_oe_o, multifunction_od_port_pu_o,
    open_drain_nibble_port_oe_o, open_drain_nibble_port_pu_o, multifunction_od_port_o,
    open_drain_nibble_port_o};
  mpf_port_pins #(.ADDR_W(12)) u_dut (.*);
  mpf_prog_model u_pgm (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(pg_go), .pulses_i(pg_n),
    .drive_i(pg_drv), .wdata_i(8'hC3), .step_o(prog_step_clk_i), .data_o(pg_data),
    .busy_o(pg_busy));
  // ----
  // tasks
  // ----
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    if (n >= 50) num_errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] n);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    pg_n <= n;
    pg_go <= 1'b1;
    @(posedge clk_sys_i);
    pg_go <= 1'b0;
    @(negedge clk_sys_i);
    while (pg_busy !== 1'b0 && k < 200) begin
      @(negedge clk_sys_i);
      k++;
    end
    settle();
  endtask
  task automatic setmd(input logic [3:0] v);
    @(posedge clk_sys_i);
    md <= v;
    settle();
  endtask
  // ----
  // clock, watchdog and sequence
  // ----
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    settle();
    chk("oe_reset", 32'h0, {28'h0, oe_all});
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0, q);
      chk("reset_value", 32'h0, q);
    end
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, q);
      bus(1'b0, rows[i].a, 32'h0, q);
      chk("readback", rows[i].e, q);
    end
    settle();
    chk("pp_drive", 32'hF50FAF3, {4'h0, pp});
    chk("od_drive", 32'h6F9F00, {8'h0, od});
    bus(1'b1, 8'h14, 32'h5A4, q);
    settle();
    chk("dir_bits", 32'h0FA49, {12'h0, pp[27:24], pp[19:16], pp[7:4], od[23:20], od[15:12]});
    bus(1'b0, 8'h20, 32'h0, q);
    chk("pin_in", 32'h354321, q);
    bus(1'b1, 8'h1C, 32'h7, q);
    settle();
    chk("alt_func", 32'h62, {od[23:20], 2'h0, serial_data_in_o, serial_clock_in_o});
    @(posedge clk_sys_i);
    two_bit_input_port_i <= 2'b10;
    settle();
    chk("release_irq", 32'h3, {30'h0, standby_release_o, irq_o});
    bus(1'b0, 8'h24, 32'h0, q);
    chk("irq_status", 32'h1, q);
    bus(1'b1, 8'h28, 32'h1, q);
    bus(1'b1, 8'h2C, 32'h4, q);
    @(posedge clk_sys_i);
    two_bit_input_port_i <= 2'b11;
    ext_int_pin_i <= 1'b1;
    settle();
    bus(1'b0, 8'h24, 32'h0, q);
    chk("int_masked", 32'h2, {q[31:1], irq_o});
    chk("int_release", 32'h1, {31'h0, standby_release_o});
    bus(1'b1, 8'h28, 32'h7, q);
    @(posedge clk_sys_i);
    ext_int_pin_i <= 1'b0;
    prog_mode_i <= 1'b1;
    settle();
    pulse(4'h4);
    chk("clear_holds", 32'h0, {20'h0, prog_addr_o});
    setmd(4'hD);
    pulse(4'h4);
    chk("step_4", 32'h1001, {19'h0, irq_o, prog_addr_o});
    pulse(4'h3);
    chk("step_3", 32'h1, {20'h0, prog_addr_o});
    pulse(4'h1);
    chk("step_1", 32'h2, {20'h0, prog_addr_o});
    setmd(4'hE);
    chk("write_mode", 32'h2C3, {22'h0, prog_write_o, prog_verify_o, prog_wdata_o});
    @(posedge clk_sys_i);
    pg_drv <= 1'b0;
    setmd(4'hC);
    chk("verify", 32'h2FF5A, {14'h0, prog_verify_o, prog_write_o, pp[27:24], pp[15:12],
      pp[11:8], pp[23:20]});
    setmd(4'h5);
    chk("addr_clear", 32'h0, {18'h0, prog_write_o, prog_verify_o, prog_addr_o});
    @(posedge clk_sys_i);
    prog_mode_i <= 1'b0;
    rst_n_i <= 1'b0;
    settle();
    chk("oe_mid_reset", 32'h0, {28'h0, oe_all});
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    bus(1'b0, 8'h14, 32'h0, q);
    chk("dir_after_reset", 32'h0, q);
    conclude();
  end
endmodule

// ==== test/mpf_prog_model.sv ====
/* programmer side of the programming pins: step pulse trains and data bus.
   assumes clk_sys_i and rst_n_i from the bench. */
`timescale 1ns/1ps
module mpf_prog_model (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire go_i,
  input wire [3:0] pulses_i,
  input wire drive_i,
  input wire [7:0] wdata_i,
  output reg step_o,
  output reg [7:0] data_o,
  output wire busy_o
);
  reg [3:0] left_q;
  reg [1:0] ph_q;
  assign busy_o = (left_q != 4'h0);
  // pulse train, two cycles high then two low per pulse; data bus toggles when released
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_q <= 4'h0;
      ph_q <= 2'h0;
      step_o <= 1'b0;
      data_o <= 8'h00;
    end else begin
      data_o <= drive_i ? wdata_i : ~data_o;
      if (go_i && !busy_o) begin
        left_q <= pulses_i;
      end else if (busy_o) begin
        ph_q <= ph_q + 2'h1;
        step_o <= !ph_q[1];
        left_q <= (ph_q == 2'h3) ? left_q - 4'h1 : left_q;
      end
    end
  end
endmodule
